// [rtl/sim_pkg.sv]
// constants shared by the stage interrupt enable block
package sim_pkg;
   localparam int unsigned NUM_STAGES = 12;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_HIGH_MASK = 4'h6;
   localparam logic [ADDR_W-1:0] IDX_DONE_MASK = 4'h7;
   localparam logic [ADDR_W-1:0] IDX_LOW_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] IDX_HIGH_STATUS = 4'h9;
   localparam logic [ADDR_W-1:0] IDX_EVT_STATUS = 4'hA;
   localparam logic [ADDR_W-1:0] IDX_EVT_MASK = 4'hB;
   // field layout
   localparam int unsigned GPIO_EN_BIT = 12;
   localparam logic [15:0] HIGH_MASK_WMASK = 16'h0FFF;
   localparam logic [15:0] DONE_MASK_WMASK = 16'h1FFF;
   localparam logic [15:0] HIGH_MASK_RESET = 16'h0000;
   localparam logic [15:0] DONE_MASK_RESET = 16'h0000;
   localparam logic [15:0] EVT_MASK_RESET = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
   // event status bits
   localparam int unsigned EVT_HIGH = 0;
   localparam int unsigned EVT_DONE = 1;
   localparam int unsigned EVT_GPIO = 2;
   localparam int unsigned EVT_W = 3;
endpackage

// [rtl/sim_stage_irq.sv]
// stage interrupt enable registers, threshold status and interrupt outputs
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sim_stage_irq #(
   parameter int unsigned STAGES = sim_pkg::NUM_STAGES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // avalon-mm slave, word addressed
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // sequencer events, one-cycle pulses / levels
   input wire logic [STAGES-1:0] stage_above_high,
   input wire logic [STAGES-1:0] stage_below_low,
   input wire logic [STAGES-1:0] stage_done,
   input wire logic gpio_changed,
   // interrupt
   output logic int_n,
   output logic irq
);
   typedef struct packed {
      logic [15:0] high_mask;
      logic [15:0] done_mask;
      logic [STAGES-1:0] high_stat;
      logic [STAGES-1:0] low_stat;
      logic [STAGES-1:0] done_pend;
      logic gpio_pend;
      logic [sim_pkg::EVT_W-1:0] evt_stat;
      logic [sim_pkg::EVT_W-1:0] evt_mask;
      logic [31:0] rdata;
      logic ack;
      logic int_n;
      logic irq;
   } sim_state_type;

   sim_state_type cur;
   sim_state_type next_cur;
   logic [3:0] idx;
   logic req;
   logic [15:0] wd;
   logic [15:0] be_mask;

   assign idx = avs_address[3:0];
   assign req = (avs_read | avs_write) & ~cur.ack;
   assign wd = avs_writedata[15:0];
   assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_comb begin
      logic hit_high;
      logic hit_done;
      logic hit_gpio;
      logic pend;
      logic [15:0] wm;
      hit_high = 1'b0;
      hit_done = 1'b0;
      hit_gpio = 1'b0;
      pend = 1'b0;
      wm = 16'h0000;
      next_cur = cur;
      next_cur.ack = req;
      // status flags follow the sequencer; they stay sticky until a read
      next_cur.high_stat = cur.high_stat | stage_above_high;
      next_cur.low_stat = cur.low_stat | stage_below_low;
      next_cur.done_pend = cur.done_pend | stage_done;
      next_cur.gpio_pend = cur.gpio_pend | gpio_changed;
      if (req && avs_read) begin
         case (idx)
            sim_pkg::IDX_HIGH_MASK: next_cur.rdata = {16'h0000, cur.high_mask};
            sim_pkg::IDX_DONE_MASK: next_cur.rdata = {16'h0000, cur.done_mask};
            sim_pkg::IDX_LOW_STATUS: begin
               next_cur.rdata = 32'(cur.low_stat);
               next_cur.low_stat = stage_below_low;
            end
            sim_pkg::IDX_HIGH_STATUS: begin
               next_cur.rdata = 32'(cur.high_stat);
               // reading also retires completion and gpio pends; new events win
               next_cur.high_stat = stage_above_high;
               next_cur.done_pend = stage_done;
               next_cur.gpio_pend = gpio_changed;
            end
            sim_pkg::IDX_EVT_STATUS: next_cur.rdata = 32'(cur.evt_stat);
            sim_pkg::IDX_EVT_MASK: next_cur.rdata = 32'(cur.evt_mask);
            default: next_cur.rdata = sim_pkg::UNMAPPED_READ;
         endcase
      end
      if (req && avs_write) begin
         case (idx)
            sim_pkg::IDX_HIGH_MASK: begin
               wm = be_mask & sim_pkg::HIGH_MASK_WMASK;
               next_cur.high_mask = (cur.high_mask & ~wm) | (wd & wm);
            end
            sim_pkg::IDX_DONE_MASK: begin
               // unused upper bits stay zero whatever is written
               wm = be_mask & sim_pkg::DONE_MASK_WMASK;
               next_cur.done_mask = (cur.done_mask & ~wm) | (wd & wm);
            end
            sim_pkg::IDX_EVT_STATUS: next_cur.evt_stat = cur.evt_stat & ~wd[2:0];
            sim_pkg::IDX_EVT_MASK: next_cur.evt_mask = wd[2:0];
            default: ;
         endcase
      end
      // gating on current state, so disabled sources never reach the pin
      hit_high = |(cur.high_stat & cur.high_mask[STAGES-1:0]);
      hit_done = |(cur.done_pend & cur.done_mask[STAGES-1:0]);
      hit_gpio = cur.gpio_pend & cur.done_mask[sim_pkg::GPIO_EN_BIT];
      pend = hit_high | hit_done | hit_gpio;
      next_cur.int_n = ~pend;
      // sticky event bits: set beats write-one-to-clear
      next_cur.evt_stat[sim_pkg::EVT_HIGH] = next_cur.evt_stat[sim_pkg::EVT_HIGH] | hit_high;
      next_cur.evt_stat[sim_pkg::EVT_DONE] = next_cur.evt_stat[sim_pkg::EVT_DONE] | hit_done;
      next_cur.evt_stat[sim_pkg::EVT_GPIO] = next_cur.evt_stat[sim_pkg::EVT_GPIO] | hit_gpio;
      next_cur.irq = |(next_cur.evt_stat & next_cur.evt_mask);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
         cur.high_mask <= sim_pkg::HIGH_MASK_RESET;
         cur.done_mask <= sim_pkg::DONE_MASK_RESET;
         cur.evt_mask <= sim_pkg::EVT_MASK_RESET[sim_pkg::EVT_W-1:0];
         cur.int_n <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign avs_readdata = cur.rdata;
   assign avs_waitrequest = ~cur.ack;
   assign int_n = cur.int_n;
   assign irq = cur.irq;

   a_high_gate: assert property (@(posedge ref_clk) disable iff (rst)
      (|(cur.high_stat & cur.high_mask[STAGES-1:0])) |=> !int_n)
      else $error("enabled over-threshold did not pull interrupt low");
   a_masked_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.high_mask == 16'h0000 && cur.done_mask == 16'h0000) |=> int_n)
      else $error("interrupt asserted with every source disabled");
   a_high_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
      cur.high_mask[15:12] == 4'h0)
      else $error("high mask upper bits not zero");
   a_done_gate: assert property (@(posedge ref_clk) disable iff (rst)
      (|(cur.done_pend & cur.done_mask[STAGES-1:0])) |=> !int_n)
      else $error("enabled completion did not pull interrupt low");
   a_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
      (avs_write && !avs_waitrequest && avs_address[3:0] == 4'h7 && avs_byteenable == 4'hF)
      |=> cur.done_mask == ($past(avs_writedata[15:0]) & 16'h1FFF))
      else $error("done mask write not stored");
   a_done_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
      cur.done_mask[15:13] == 3'h0)
      else $error("done mask unused bits not zero");
   a_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (req && avs_read && idx == 4'h9 && stage_above_high == '0) |=> cur.high_stat == '0)
      else $error("high status did not self-clear on read");
   a_int_release: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.high_stat == '0 && cur.done_pend == '0 && !cur.gpio_pend) |=> int_n)
      else $error("interrupt held with nothing pending");
   a_wait_bound: assert property (@(posedge ref_clk) disable iff (rst)
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("bus access not answered in one cycle");

   // bus answer shape: one low cycle, high again when idle
   a_wait_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_wait_idle: assert property (@(posedge ref_clk) disable iff (rst)
      (!avs_read && !avs_write) |=> avs_waitrequest)
      else $error("answer given without a request");

   a_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
      !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   // gating, status and mask writes, per source
   a_gpio_gate: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.gpio_pend && cur.done_mask[sim_pkg::GPIO_EN_BIT]) |=> !int_n)
      else $error("enabled gpio change did not pull interrupt low");

   a_low_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (req && avs_read && idx == 4'h8 && stage_below_low == '0) |=> cur.low_stat == '0)
      else $error("low status did not self-clear on read");

   a_high_keep: assert property (@(posedge ref_clk) disable iff (rst)
      (stage_above_high != '0) |=> (cur.high_stat != '0))
      else $error("over-threshold event lost from status");

   a_done_keep: assert property (@(posedge ref_clk) disable iff (rst)
      (stage_done != '0) |=> (cur.done_pend != '0))
      else $error("completion event lost");

   a_high_write: assert property (@(posedge ref_clk) disable iff (rst)
      (avs_write && !avs_waitrequest && avs_address[3:0] == 4'h6 && avs_byteenable == 4'hF)
      |=> cur.high_mask == ($past(avs_writedata[15:0]) & 16'h0FFF))
      else $error("high mask write not stored");

   // low flags have no enable in this block, so they must never reach the pin
   a_low_isolated: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.high_stat == '0 && cur.done_pend == '0 && !cur.gpio_pend && cur.low_stat != '0)
      |=> int_n)
      else $error("low flag drove the interrupt");

   a_done_masked: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.done_mask == 16'h0000 && cur.high_stat == '0) |=> int_n)
      else $error("disabled completion drove the interrupt");

   a_high_masked: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.high_mask == 16'h0000 && cur.done_pend == '0 && !cur.gpio_pend) |=> int_n)
      else $error("disabled over-threshold drove the interrupt");

   // a mask write in the same cycle may legally raise irq next cycle
   a_irq_off: assert property (@(posedge ref_clk) disable iff (rst)
      (cur.evt_mask == '0 && !(req && avs_write && idx == 4'hB)) |=> !irq)
      else $error("irq raised with every event masked");
endmodule

// [verification/sim_host_model.sv]
// host model: avalon master that reads and writes the block's registers
`timescale 1ns/1ps
module sim_host_model (
   // clock
   input wire logic ref_clk,
   // avalon-mm master side
   output logic [5:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
   end
   task automatic xfer(input logic w, input logic [3:0] i, input logic [15:0] d,
      output logic [15:0] q);
      @(posedge ref_clk);
      avs_address <= {2'h0, i};
      avs_read <= ~w;
      avs_write <= w;
      avs_writedata <= {16'h0000, d};
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released lines flip so a stale value never reads as data
      avs_address <= ~avs_address;
      avs_writedata <= ~avs_writedata;
   endtask
endmodule

// [verification/sim_stage_irq_tb.sv]
// self-checking bench for the stage interrupt enable block
`timescale 1ns/1ps
module sim_stage_irq_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] a;
   logic rd, wr, wq, int_n, irq;
   logic gp = 1'b0;
   logic [31:0] wd, rdat;
   logic [3:0] be;
   logic [11:0] hi = 12'h000, lo = 12'h000, dn = 12'h000;
   logic [15:0] q, m, d;
   int err_total = 0, checked = 0, seed = 89, s, k, en;
   always #50 ref_clk = ~ref_clk;
   sim_host_model host_u (.ref_clk(ref_clk), .avs_address(a), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq));
   sim_stage_irq dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(a), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wq), .stage_above_high(hi), .stage_below_low(lo), .stage_done(dn),
      .gpio_changed(gp), .int_n(int_n), .irq(irq));
   task automatic chk(input string n, input logic [15:0] g, e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic w(input logic [3:0] i, input logic [15:0] v);
      host_u.xfer(1'b1, i, v, q);
   endtask
   task automatic r(input logic [3:0] i);
      host_u.xfer(1'b0, i, 16'h0000, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   initial begin
      #300000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      tick(6);
      rst <= 1'b0;
      r(4'h6); chk("high mask", q, 16'h0000);
      r(4'h7); chk("done mask", q, 16'h0000);
      repeat (8) begin
         d = $random(seed);
         w(4'h6, d); w(4'h7, d); w(4'h3, d);
         r(4'h6); chk("high mask", q, d & 16'h0FFF);
         r(4'h7); chk("done mask", q, d & 16'h1FFF);
         r(4'h3); chk("unmapped", q, 16'h0000);
      end
      for (k = 0; k < 3; k++) for (en = 0; en < 2; en++) begin
         s = $unsigned($random(seed)) % 12;
         m = (k == 2) ? 16'h1000 : (16'h0001 << s);
         if (en == 0) m = ~m & ((k == 0) ? 16'h0FFF : 16'h1FFF);
         w((k == 0) ? 4'h6 : 4'h7, m);
         w((k == 0) ? 4'h7 : 4'h6, 16'h0000);
         @(posedge ref_clk);
         if (k == 0) hi <= 12'h001 << s;
         else if (k == 1) dn <= 12'h001 << s;
         else gp <= 1'b1;
         @(posedge ref_clk);
         hi <= 12'h000; dn <= 12'h000; gp <= 1'b0;
         tick(3);
         chk("int_n", {15'h0000, int_n}, {15'h0000, en == 0});
         chk("irq", {15'h0000, irq}, 16'h0000);
         r(4'h9); chk("high status", q, (k == 0) ? 16'h0001 << s : 16'h0000);
         r(4'h9); chk("high status", q, 16'h0000);
         tick(2); chk("int_n", {15'h0000, int_n}, 16'h0001);
      end
      w(4'hA, 16'h0007); r(4'hA); chk("event status", q, 16'h0000);
      w(4'hB, 16'h0007); w(4'h7, 16'h0001);
      @(posedge ref_clk) dn <= 12'h001;
      @(posedge ref_clk) dn <= 12'h000;
      tick(3); chk("irq", {15'h0000, irq}, 16'h0001);
      // completion pend must be retired first, else the still-set source wins over the clear
      r(4'h9);
      w(4'hA, 16'h0002); tick(2); chk("irq", {15'h0000, irq}, 16'h0000);
      tally_and_finish;
   end
endmodule
